/* design/psar_pause_resolve.sv */
// pause resolution: picks one pause kind from the advertised and partner fields
`default_nettype none
module psar_pause_resolve
  import psar_pkg::*;
(
  input wire logic [1:0] i_local,
  input wire logic [1:0] i_partner,
  output logic [1:0] o_mode
);
  // both-kinds advertise collapses to one kind; symmetric preferred when partner offers it
  wire logic partner_sym = i_partner[0];
  wire logic both_local = (i_local == PSAR_PAUSE_BOTH);
  wire logic [1:0] both_pick = partner_sym ? PSAR_PAUSE_SYM :
                               (i_partner[1] ? PSAR_PAUSE_ASYM : PSAR_PAUSE_NONE);
  wire logic [1:0] common = i_local & i_partner;
  wire logic [1:0] single_pick = common[0] ? PSAR_PAUSE_SYM :
                                 (common[1] ? PSAR_PAUSE_ASYM : PSAR_PAUSE_NONE);
  assign o_mode = both_local ? both_pick : single_pick;
endmodule
`default_nettype wire

/* design/psar_phy_status_autoneg_regs.sv */
// PHY status, identifier, advertisement and link partner registers behind indexed access
//
// Operation
// - abilities 14..11 one, T4 bit zero
// - bit 5 shows negotiation finished
// - bit 4 latches remote fault high
// - bit 2 shows link up
// - bit 1 shows jabber condition
// - bit 3 one, bits 10..6 zero
// - bit 0 one, extended registers present
// - identifier high word holds OUI 3..18
// - low word: OUI 19..24, model, revision
// - pause field writable, resets to 00
// - both-kinds pause resolves to one kind
// - advertised ability bits 8..5 reset one
// - bit 13 writable fault, 12 reserved writable
// - selector 00001, writable only in advertisement
// - partner next page bit reads zero
// - partner acknowledge bit reads zero
// - partner pause field read-only, resets 00
// - partner abilities read-only, reset zero
`default_nettype none
module psar_phy_status_autoneg_regs
  import psar_pkg::*;
#(
  parameter logic [15:0] OUI_HIGH = PSAR_OUI_HIGH_DEF, // arbitrary value
  parameter logic [5:0] OUI_LOW = PSAR_OUI_LOW_DEF, // arbitrary value
  parameter logic [5:0] MODEL = PSAR_MODEL_DEF, // arbitrary value
  parameter logic [3:0] REVISION = PSAR_REV_DEF // arbitrary value
)
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire psar_mgmt_req_s i_mgmt,
  output logic [15:0] o_rdata,
  output logic o_rvalid,
  input wire psar_line_s i_line,
  output logic [15:0] o_adv_word,
  output logic [1:0] o_pause_mode,
  output logic o_pause_valid
);
  ////////////////////////////////////////////////////////////////////////////
  // state
  logic [15:0] adv; // advertisement word
  logic [15:0] partner; // received partner abilities
  logic rfault_latch; // latch-high remote fault
  logic an_done; // negotiation finished
  logic link_up; // live link state
  logic jabber; // live jabber state
  psar_neg_e neg_state; // tracks completion for pause resolution
  logic [1:0] pause_mode; // resolved pause kind
  ////////////////////////////////////////////////////////////////////////////
  // decode of the indexed access
  wire logic is_rd = i_mgmt.req & ~i_mgmt.wr;
  wire logic is_wr = i_mgmt.req & i_mgmt.wr;
  wire logic hit_status = (i_mgmt.idx == PSAR_IDX_STATUS);
  wire logic hit_adv = (i_mgmt.idx == PSAR_IDX_ADV);
  wire logic rd_status = is_rd & hit_status;
  wire logic wr_adv = is_wr & hit_adv;
  ////////////////////////////////////////////////////////////////////////////
  // assembled read words
  logic [15:0] status_word;
  always_comb begin
    status_word = PSAR_ST_CONST;
    status_word[PSAR_ST_AN_DONE] = an_done;
    status_word[PSAR_ST_RFAULT] = rfault_latch;
    status_word[PSAR_ST_LINK] = link_up;
    status_word[PSAR_ST_JABBER] = jabber;
  end
  wire logic [15:0] id_high_word = OUI_HIGH;
  wire logic [15:0] id_low_word = {OUI_LOW, MODEL, REVISION};
  // partner: bits 15,14,12 forced zero, selector fixed
  wire logic [15:0] partner_word = (partner & PSAR_LP_MASK) | PSAR_LP_RESET;
  // read mux; unlisted indexes read zero
  logic [15:0] read_word;
  always_comb begin
    case (i_mgmt.idx)
      PSAR_IDX_STATUS: read_word = status_word;
      PSAR_IDX_ID_HIGH: read_word = id_high_word;
      PSAR_IDX_ID_LOW: read_word = id_low_word;
      PSAR_IDX_ADV: read_word = adv;
      PSAR_IDX_PARTNER: read_word = partner_word;
      default: read_word = 16'h0000;
    endcase
  end
  // next advertisement: writable bits from host, read-only bits keep zero
  wire logic [15:0] next_adv = (i_mgmt.wdata & PSAR_ADV_WMASK);
  ////////////////////////////////////////////////////////////////////////////
  // read data register
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_rdata <= 16'h0000;
      o_rvalid <= 1'b0;
    end else begin
      o_rvalid <= is_rd;
      if (is_rd) begin
        o_rdata <= read_word;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // advertisement register
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      adv <= PSAR_ADV_RESET;
    end else if (wr_adv) begin
      adv <= next_adv;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // live status bits follow the line
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      an_done <= 1'b0;
      link_up <= 1'b0;
      jabber <= 1'b0;
    end else begin
      an_done <= i_line.an_done;
      link_up <= i_line.link_up;
      jabber <= i_line.jabber;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // remote fault latch: set wins over clear-on-read; read clears only if gone
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      rfault_latch <= 1'b0;
    end else if (i_line.rfault) begin
      rfault_latch <= 1'b1;
    end else if (rd_status) begin
      rfault_latch <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // partner abilities captured from received code word
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      partner <= 16'h0000;
    end else if (i_line.lp_valid) begin
      partner <= i_line.lp_word & PSAR_LP_MASK;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // pause resolution on negotiation completion
  logic [1:0] resolved;
  psar_pause_resolve u_pause (
    .i_local(adv[PSAR_PAUSE_LSB +: 2]),
    .i_partner(partner[PSAR_PAUSE_LSB +: 2]),
    .o_mode(resolved)
  );
  // resolution is taken once at completion so a later write does not flip mode mid-link
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      neg_state <= PSAR_NEG_IDLE;
      pause_mode <= PSAR_PAUSE_NONE;
    end else begin
      case (neg_state)
        PSAR_NEG_IDLE: begin
          if (an_done) begin
            neg_state <= PSAR_NEG_DONE;
            pause_mode <= resolved;
          end
        end
        PSAR_NEG_DONE: begin
          if (!an_done) begin
            neg_state <= PSAR_NEG_IDLE;
            pause_mode <= PSAR_PAUSE_NONE;
          end
        end
        default: begin
          neg_state <= PSAR_NEG_IDLE;
        end
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // outputs to the negotiation engine
  assign o_adv_word = adv;
  assign o_pause_mode = pause_mode;
  assign o_pause_valid = (neg_state == PSAR_NEG_DONE);
endmodule
`default_nettype wire

/* design/psar_pkg.sv */
// package: register indexes, field positions, reset values and link types for the PHY regs
`default_nettype none
package psar_pkg;
  // register indexes as the management access selects them
  localparam logic [4:0] PSAR_IDX_STATUS = 5'h01;
  localparam logic [4:0] PSAR_IDX_ID_HIGH = 5'h02;
  localparam logic [4:0] PSAR_IDX_ID_LOW = 5'h03;
  localparam logic [4:0] PSAR_IDX_ADV = 5'h04;
  localparam logic [4:0] PSAR_IDX_PARTNER = 5'h05;
  // status word field positions
  localparam int PSAR_ST_AN_DONE = 5;
  localparam int PSAR_ST_RFAULT = 4;
  localparam int PSAR_ST_LINK = 2;
  localparam int PSAR_ST_JABBER = 1;
  // constant parts of the status word: abilities 14..11, an able 3, extended 0
  localparam logic [15:0] PSAR_ST_CONST = 16'h7809;
  // advertisement: writable bit mask and reset value
  localparam logic [15:0] PSAR_ADV_WMASK = 16'h3DFF;
  localparam logic [15:0] PSAR_ADV_RESET = 16'h01E1;
  // partner word: bits taken from the received code word, and reset value
  localparam logic [15:0] PSAR_LP_MASK = 16'h2FE0;
  localparam logic [15:0] PSAR_LP_RESET = 16'h0001;
  // pause field position and codes
  localparam int PSAR_PAUSE_LSB = 10;
  localparam logic [1:0] PSAR_PAUSE_NONE = 2'h0;
  localparam logic [1:0] PSAR_PAUSE_SYM = 2'h1;
  localparam logic [1:0] PSAR_PAUSE_ASYM = 2'h2;
  localparam logic [1:0] PSAR_PAUSE_BOTH = 2'h3;
  // identity defaults: arbitrary neutral values, not any real part's code
  localparam logic [15:0] PSAR_OUI_HIGH_DEF = 16'h1234;
  localparam logic [5:0] PSAR_OUI_LOW_DEF = 6'h15;
  localparam logic [5:0] PSAR_MODEL_DEF = 6'h2A;
  localparam logic [3:0] PSAR_REV_DEF = 4'h1;
  // management access request from the host MAC
  typedef struct packed {
    logic req;
    logic wr;
    logic [4:0] idx;
    logic [15:0] wdata;
  } psar_mgmt_req_s;
  // line events reported by the negotiation and link logic
  typedef struct packed {
    logic an_done;
    logic rfault;
    logic link_up;
    logic jabber;
    logic lp_valid;
    logic [15:0] lp_word;
  } psar_line_s;
  typedef enum logic [1:0] {
    PSAR_NEG_IDLE = 2'b00,
    PSAR_NEG_DONE = 2'b01
  } psar_neg_e;
endpackage
`default_nettype wire

/* verification/psar_host_model.sv */
// host MAC model: indexed management access toward the PHY registers
`default_nettype none
module psar_host_model
  import psar_pkg::*;
(
  input wire logic i_clk,
  output psar_mgmt_req_s o_mgmt
);
  initial o_mgmt = '0; // idle until the first access
  // one access: request held through the taking edge, then released
  task automatic access(input logic wr, input logic [4:0] idx, input logic [15:0] wd);
    @(posedge i_clk);
    #1;
    o_mgmt = '{req: 1'b1, wr: wr, idx: idx, wdata: wd};
    @(posedge i_clk);
    #1;
    // released lines show garbage so stale values never pass
    o_mgmt = '{req: 1'b0, wr: ~wr, idx: ~idx, wdata: ~wd};
  endtask
endmodule
`default_nettype wire

/* verification/psar_phy_status_autoneg_regs_tb.sv */
// testbench: reset values, writes, latch-high and line events of the PHY regs
`default_nettype none
module psar_phy_status_autoneg_regs_tb;
  import psar_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'b0; // 40 MHz bench clock
  logic i_sys_rst = 1'b1; // held three edges at start
  psar_line_s line = '0; // far-side line events
  psar_mgmt_req_s mgmt; // host requests
  logic [15:0] rdata, adv;
  logic rvalid, pvalid;
  logic [1:0] pmode;
  int n_errors = 0;
  int samples_checked = 0;
  initial forever #12.5 i_clk = ~i_clk;
  psar_host_model u_host (.i_clk(i_clk), .o_mgmt(mgmt));
  psar_phy_status_autoneg_regs DUT (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_mgmt(mgmt),
    .o_rdata(rdata), .o_rvalid(rvalid), .i_line(line), .o_adv_word(adv),
    .o_pause_mode(pmode), .o_pause_valid(pvalid));
  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checked %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // inputs move 1 ns after the edge so sampling never races
  task automatic step(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  // read answer stands only in the cycle after the taking edge
  task automatic rd(input logic [4:0] idx, input logic [15:0] exp);
    u_host.access(1'b0, idx, 16'h0000);
    chk({15'h0, rvalid}, 16'h0001);
    chk(rdata, exp);
  endtask
  task automatic do_reset();
    i_sys_rst = 1'b1;
    step(3);
    i_sys_rst = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd(5'h01, 16'h7809);
    rd(5'h02, PSAR_OUI_HIGH_DEF);
    rd(5'h03, {PSAR_OUI_LOW_DEF, PSAR_MODEL_DEF, PSAR_REV_DEF});
    rd(5'h04, 16'h01E1);
    rd(5'h05, 16'h0001);
    rd(5'h07, 16'h0000);
    chk(adv, 16'h01E1);
  endtask
  task automatic t_adv();
    u_host.access(1'b1, 5'h04, 16'hFFFF);
    rd(5'h04, 16'h3DFF);
    u_host.access(1'b1, 5'h02, 16'h0000);
    rd(5'h02, PSAR_OUI_HIGH_DEF);
    // every pause code, abilities cleared to show they are writable
    for (int p = 0; p < 4; p++) begin
      u_host.access(1'b1, 5'h04, {4'h0, 2'(p), 10'h001});
      rd(5'h04, {4'h0, 2'(p), 10'h001});
    end
  endtask
  // remote fault pulse must stick until one read clears it
  task automatic t_rfault();
    line.rfault = 1'b1;
    step(2);
    line.rfault = 1'b0;
    step(2);
    rd(5'h01, 16'h7819);
    rd(5'h01, 16'h7809);
  endtask
  task automatic t_line();
    line.link_up = 1'b1;
    line.jabber = 1'b1;
    line.lp_word = 16'hF7FF; // partner: symmetric pause only
    line.lp_valid = 1'b1;
    step(1);
    line.lp_valid = 1'b0;
    rd(5'h01, 16'h780F);
    rd(5'h05, 16'h27E1);
    u_host.access(1'b1, 5'h04, 16'h0DE1);
    step(1);
    line.an_done = 1'b1;
    step(3);
    chk({14'h0, pmode}, 16'h0001);
    chk({15'h0, pvalid}, 16'h0001);
    rd(5'h01, 16'h782F);
  endtask
  // completion drop, asymmetric pick, and fault set winning over a read clear
  task automatic t_pause();
    line.an_done = 1'b0;
    step(3);
    chk({15'h0, pvalid}, 16'h0000);
    chk({14'h0, pmode}, 16'h0000);
    line.lp_word = 16'h0800; // partner: asymmetric pause only
    line.lp_valid = 1'b1;
    step(1);
    line.lp_valid = 1'b0;
    line.an_done = 1'b1;
    step(3);
    chk({14'h0, pmode}, 16'h0002);
    line.rfault = 1'b1;
    rd(5'h01, 16'h783F);
    line.rfault = 1'b0;
    rd(5'h01, 16'h783F);
    rd(5'h01, 16'h782F);
  endtask
  initial begin
    #50us;
    n_errors++;
    summarize();
  end
  initial begin
    do_reset();
    t_reset();
    t_adv();
    t_rfault();
    t_line();
    t_pause();
    line = '0;
    do_reset();
    t_reset();
    summarize();
  end
endmodule
`default_nettype wire

/* verification/psar_regs_chk.sv */
// checker: port-level assertions for the PHY register block
`default_nettype none
module psar_regs_chk
  import psar_pkg::*;
#(
  parameter logic [15:0] OUI_HIGH = PSAR_OUI_HIGH_DEF, // arbitrary value
  parameter logic [5:0] OUI_LOW = PSAR_OUI_LOW_DEF, // arbitrary value
  parameter logic [5:0] MODEL = PSAR_MODEL_DEF, // arbitrary value
  parameter logic [3:0] REVISION = PSAR_REV_DEF // arbitrary value
)
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire psar_mgmt_req_s i_mgmt,
  input wire logic [15:0] o_rdata,
  input wire logic o_rvalid,
  input wire psar_line_s i_line,
  input wire logic [15:0] o_adv_word,
  input wire logic [1:0] o_pause_mode,
  input wire logic o_pause_valid
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // request kinds, named once so properties stay short
  wire logic rd = i_mgmt.req && !i_mgmt.wr;
  wire logic wr4 = i_mgmt.req && i_mgmt.wr && (i_mgmt.idx == PSAR_IDX_ADV);
  a_read_answer: assert property (rd |=> o_rvalid)
    else $error("read not answered next cycle");
  a_no_spurious: assert property (!rd |=> !o_rvalid)
    else $error("read data valid without a read");
  a_status_fixed: assert property (rd && i_mgmt.idx == PSAR_IDX_STATUS
    |=> (o_rdata & 16'hFFC9) == PSAR_ST_CONST) else $error("status constant bits wrong");
  a_status_line: assert property (rd && i_mgmt.idx == PSAR_IDX_STATUS && !$past(i_sys_rst)
    |=> {o_rdata[5], o_rdata[2], o_rdata[1]}
    == $past({i_line.an_done, i_line.link_up, i_line.jabber}, 2))
    else $error("status line bits wrong");
  a_id_high: assert property (rd && i_mgmt.idx == PSAR_IDX_ID_HIGH |=> o_rdata == OUI_HIGH)
    else $error("identifier high word wrong");
  a_id_low: assert property (rd && i_mgmt.idx == PSAR_IDX_ID_LOW
    |=> o_rdata == {OUI_LOW, MODEL, REVISION}) else $error("identifier low word wrong");
  a_lp_fixed: assert property (rd && i_mgmt.idx == PSAR_IDX_PARTNER
    |=> o_rdata[15:14] == 2'h0 && !o_rdata[12] && o_rdata[4:0] == 5'h01)
    else $error("partner fixed bits wrong");
  a_adv_write: assert property (wr4
    |=> o_adv_word == ($past(i_mgmt.wdata) & PSAR_ADV_WMASK)) else $error("adv write wrong");
  a_adv_hold: assert property (!wr4 |=> $stable(o_adv_word))
    else $error("adv word changed without write");
  a_pause_one: assert property (o_pause_mode != PSAR_PAUSE_BOTH)
    else $error("pause resolved to both kinds");
endmodule
bind psar_phy_status_autoneg_regs psar_regs_chk #(.OUI_HIGH(OUI_HIGH), .OUI_LOW(OUI_LOW),
  .MODEL(MODEL), .REVISION(REVISION)) u_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
  .i_mgmt(i_mgmt), .o_rdata(o_rdata), .o_rvalid(o_rvalid), .i_line(i_line),
  .o_adv_word(o_adv_word), .o_pause_mode(o_pause_mode), .o_pause_valid(o_pause_valid));
`default_nettype wire
